// ### pkg/act_pkg.sv
// Constants, carrier types and states of the active power datapath
package act_pkg;

  // Sample and accumulator widths
  localparam int SAMPLE_W = 24;
  localparam int ACC_W = 48;

  // Decimator: ones counted over a window of 256 modulator bits
  localparam int DEC_CNT_W = 8;
  localparam logic [DEC_CNT_W-1:0] DEC_LAST = 8'hFF;
  localparam logic signed [SAMPLE_W-1:0] DEC_MID = 24'h00_0100;
  localparam int DEC_SHIFT = 14;

  // Filter corner shifts and product scaling
  localparam int HPF_SHIFT = 16;
  localparam int LPF_SHIFT = 7; // Active value settles within a few hundred samples

  // Energy per output pulse, counted in accumulated power units
  localparam logic [ACC_W-1:0] CF_THRESH = 48'h0000_4000_0000;
  localparam logic [ACC_W-1:0] LR_THRESH = 48'h0200_0000_0000;

  // Sample FIFO depth
  localparam int FIFO_DEPTH = 16;

  // Clock rate and pulse high times
  localparam int CLK_MHZ = 32'h0000_00C8;
  localparam int CF_HIGH_US = 32'h0000_000A;
  localparam int CF_HIGH_CYC = CF_HIGH_US * CLK_MHZ;
  localparam int LR_HIGH_US = 32'h0000_0064;
  localparam int LR_HIGH_CYC = LR_HIGH_US * CLK_MHZ;

  // Rate select codes
  localparam logic [1:0] RATE_X1 = 2'h0;
  localparam logic [1:0] RATE_X2 = 2'h1;
  localparam logic [1:0] RATE_X4 = 2'h2;
  localparam logic [1:0] RATE_X8 = 2'h3;

  // Current and voltage sample pair carried through the FIFO
  typedef struct packed {
    logic signed [SAMPLE_W-1:0] current;
    logic signed [SAMPLE_W-1:0] voltage;
  } act_pair_t;

  // Processing sequence
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_HPF = 5'b00010,
    ST_MUL = 5'b00100,
    ST_LPF = 5'b01000,
    ST_DFC = 5'b10000
  } act_state_t;

endpackage

// ### tb/act_power_sva.sv
// Port-level assertion checker for the active power datapath
`timescale 1ns/1ps
`default_nettype none
module act_power_chk
  import act_pkg::*;
#(
  parameter int LR_HIGH = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched input
  input wire logic supply_low,
  // Watched outputs
  input wire logic calibration_pulse_out,
  input wire logic low_rate_pulse_a,
  input wire logic low_rate_pulse_b,
  input wire logic reverse_power_flag,
  input wire logic monitor_valid,
  input wire logic signed [SAMPLE_W-1:0] monitor_sample
);
  ////////////////////////////////////////////////////////////////////
  logic [8:0] mv_gap; // Cycles since last sample strobe
  logic mv_seen; // A strobe was seen since reset
  logic [11:0] cf_hi; // Calibration high run, saturating
  logic [15:0] la_hi; // Low-rate a high run, saturating
  logic [3:0] sl_hist; // Recent undervoltage history
  logic sl_recent; // Undervoltage now or lately

  assign sl_recent = supply_low || (|sl_hist);

  // Strobe spacing tracker
  always_ff @(posedge clk) begin
    if (rst || monitor_valid) begin
      mv_gap <= '0;
    end else begin
      mv_gap <= mv_gap + 9'h001;
    end
  end

  // First strobe marker
  always_ff @(posedge clk) begin
    if (rst) begin
      mv_seen <= 1'b0;
    end else if (monitor_valid) begin
      mv_seen <= 1'b1;
    end
  end

  // Pulse width counters and undervoltage history
  always_ff @(posedge clk) begin
    cf_hi <= !calibration_pulse_out ? 12'h000 : (cf_hi == '1 ? cf_hi : cf_hi + 12'h001);
    la_hi <= !low_rate_pulse_a ? 16'h0000 : (la_hi == '1 ? la_hi : la_hi + 16'h0001);
    sl_hist <= {sl_hist[2:0], supply_low};
  end

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_RST_QUIET: assert property (disable iff (1'b0) rst |=> !(calibration_pulse_out || low_rate_pulse_a
    || low_rate_pulse_b || reverse_power_flag || monitor_valid))
    else $error("outputs not low after reset");
  AST_NO_EARLY: assert property (!mv_seen |-> !(calibration_pulse_out || low_rate_pulse_a || low_rate_pulse_b))
    else $error("pulse before any sample");
  AST_MON_PERIOD: assert property (monitor_valid && mv_seen |-> mv_gap == 9'h0FF)
    else $error("sample strobe spacing not 256");
  AST_MON_STABLE: assert property (!monitor_valid |-> $stable(monitor_sample))
    else $error("monitor sample moved without strobe");
  AST_MON_VALUE: assert property (monitor_valid |-> monitor_sample[13:0] == 14'h0000)
    else $error("monitor sample not on its step grid");
  AST_CF_WIDTH: assert property (calibration_pulse_out && cf_hi < 12'h7CF && !sl_recent |=> calibration_pulse_out)
    else $error("calibration pulse too short");
  AST_LR_WIDTH: assert property (low_rate_pulse_a && la_hi < 16'(LR_HIGH - 1) && !sl_recent |=> low_rate_pulse_a)
    else $error("low-rate pulse too short");
  AST_LR_EXCL: assert property (!(low_rate_pulse_a && low_rate_pulse_b))
    else $error("both low-rate outputs high");
  AST_UV_SILENT: assert property (supply_low [*4] |-> !(calibration_pulse_out || low_rate_pulse_a
    || low_rate_pulse_b))
    else $error("pulse during undervoltage");
  AST_REV_AT_CF: assert property ($changed(reverse_power_flag) |-> calibration_pulse_out)
    else $error("reverse flag moved outside a calibration pulse");
endmodule

bind act_power act_power_chk #(.LR_HIGH(LR_HIGH)) act_power_chk_inst (.clk(clk), .rst(rst),
  .supply_low(supply_low), .calibration_pulse_out(calibration_pulse_out), .low_rate_pulse_a(low_rate_pulse_a),
  .low_rate_pulse_b(low_rate_pulse_b), .reverse_power_flag(reverse_power_flag), .monitor_valid(monitor_valid),
  .monitor_sample(monitor_sample));
`default_nettype wire

// ### tb/act_power_tb_top.sv
// Self-checking testbench for the active power datapath
`timescale 1ns/1ps
`default_nettype none
module act_power_tb_top
  import act_pkg::*;
;
  localparam int MAX_CYC = 95000; // Run ceiling in clocks
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ia = 1'b0; // Current bit a
  logic ib = 1'b0; // Current bit b
  logic iv = 1'b0; // Voltage bit
  logic sel_b = 1'b0;
  logic [1:0] rate_select = 2'h3;
  logic supply_low = 1'b0;
  logic cal, lra, lrb, rev, mv;
  logic signed [SAMPLE_W-1:0] ms;
  logic [7:0] pa = 8'h00; // Repeating patterns, period 8
  logic [7:0] pb = 8'h00;
  logic [7:0] pv = 8'h00;
  logic [31:0] ph = '0; // Bit phase
  logic sq_mode = 1'b0; // Square-wave load
  logic anti = 1'b0; // Voltage inverted
  logic cf_q = 1'b0;
  logic lr_q = 1'b0;
  int cf_rises = 0;
  int lr_early = 0; // Low-rate pulse before any calibration pulse
  int lr_rises = 0; // Low-rate pulses seen on either output
  int lr_per_rate [4]; // Low-rate pulses counted under each rate code
  int err_total = 0;
  int n_tests = 0;
  int n_cyc = 0;
  int seed = 17099;
  int t;

  ////////////////////////////////////////////////////////////////////
  act_power #(.LR_HIGH(20)) act_power_inst (.clk(clk), .rst(rst), .current_input_a(ia), .current_input_b(ib),
    .voltage_input_bit(iv), .current_select_b(sel_b), .rate_select(rate_select), .supply_low(supply_low),
    .calibration_pulse_out(cal), .low_rate_pulse_a(lra), .low_rate_pulse_b(lrb), .reverse_power_flag(rev),
    .monitor_valid(mv), .monitor_sample(ms));

  // Clock, 5 ns period
  initial begin
    forever #2.5 clk = ~clk;
  end

  // Bitstreams change at the falling edge
  always @(negedge clk) begin
    ph = ph + 1;
    if (sq_mode) begin
      ia = ph[10];
      ib = ph[10];
      iv = ph[10] ^ anti;
    end else begin
      ia = pa[ph[2:0]];
      ib = pb[ph[2:0]];
      iv = pv[ph[2:0]];
    end
  end

  // Pulse edge counts and run ceiling, sampled where outputs are settled
  always @(negedge clk) begin
    if (cal && !cf_q) cf_rises++;
    if ((lra || lrb) && !lr_q) lr_rises++;
    if ((lra || lrb) && !lr_q && cf_rises == 0) lr_early++;
    cf_q = cal;
    lr_q = lra || lrb;
    n_cyc++;
    if (n_cyc == MAX_CYC) begin
      err_total++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Compare one value
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Expected sample of a repeating 8-bit pattern
  function automatic logic signed [SAMPLE_W-1:0] exp_sample(input logic [7:0] p);
    int n;
    n = 32 * $countones(p);
    return SAMPLE_W'((2 * n - 256) <<< 14);
  endfunction

  // Wait for k strobes; t gets spacing of the last
  task automatic wait_mv(input int k);
    for (int i = 0; i < k; i++) begin
      t = 0;
      do begin
        @(negedge clk);
        t++;
      end while (mv !== 1'b1 && t < 400);
    end
  endtask

  // Wait for calibration (0) or reverse flag (1) high
  task automatic wait_hi(input int which, input int lim);
    t = 0;
    do begin
      @(negedge clk);
      t++;
    end while ((which == 0 ? cal : rev) !== 1'b1 && t < lim);
  endtask

  // Print counts and verdict, then stop
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    // Monitor shows the unused channel; corners full-scale both ways
    for (int i = 0; i < 6; i++) begin
      sel_b = i[0];
      pa = 8'($random(seed));
      pb = 8'($random(seed));
      pv = 8'($random(seed));
      if (i == 0) pb = 8'hFF;
      if (i == 1) pa = 8'h00;
      wait_mv(3);
      check("monitor_sample", 32'(ms), 32'(exp_sample(sel_b ? pa : pb)));
      check("strobe spacing", t, 256);
    end
    // In-phase load: let the low-pass rise for 112 samples, then positive power drives calibration
    sq_mode = 1'b1;
    repeat (28672) @(negedge clk);
    wait_hi(0, 4000);
    check("calibration pulse", 32'(cal), 1);
    check("reverse flag low", 32'(rev), 0);
    // Rate codes fastest first; rising power works against these checks
    for (int r = 3; r >= 0; r--) begin
      rate_select = 2'(r);
      t = lr_rises;
      repeat (5000) @(negedge clk);
      lr_per_rate[r] = lr_rises - t;
    end
    check("rate x8 over x2", 32'(lr_per_rate[3] > lr_per_rate[1]), 1);
    check("rate x4 over x1", 32'(lr_per_rate[2] > lr_per_rate[0]), 1);
    check("calibration first", lr_early, 0);
    // Anti-phase load: negative power sets the flag at a pulse
    anti = 1'b1;
    wait_hi(1, 30000);
    check("reverse flag high", 32'(rev), 1);
    check("flag with pulse", 32'(cal), 1);
    // Undervoltage silences all pulses
    supply_low = 1'b1;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 200; i++) begin
      @(negedge clk);
      check("pulses in undervoltage", 32'({cal, lra, lrb}), 0);
    end
    supply_low = 1'b0;
    // Second reset in mid-run
    rst = 1'b1;
    repeat (3) @(negedge clk);
    check("outputs in reset", 32'({cal, lra, lrb, rev, mv}), 0);
    rst = 1'b0;
    wait_mv(1);
    check("first strobe late", 32'(t >= 256 && t <= 262), 1);
    check("pulses at first strobe", 32'({cal, lra, lrb}), 0);
    give_verdict();
  end
endmodule
`default_nettype wire

// ### verilog/act_decim.sv
// Bitstream decimator: 256 modulator bits to one signed 24-bit sample
`timescale 1ns/1ps
`default_nettype none
module act_decim
  import act_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Modulator bit, one per clock
  input wire logic bit_in,
  // Decimated sample
  output logic sample_valid,
  output logic signed [SAMPLE_W-1:0] sample
);

  logic [DEC_CNT_W-1:0] phase; // Position in window
  logic [DEC_CNT_W:0] ones; // Ones seen so far

  // Maps a ones count to a signed level centred on zero
  function automatic logic signed [SAMPLE_W-1:0] to_level(input logic [DEC_CNT_W:0] n);
    to_level = ($signed({14'h0000, n, 1'b0}) - DEC_MID) <<< DEC_SHIFT;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Window phase, free running
  always_ff @(posedge clk) begin
    if (rst) begin
      phase <= '0;
    end else begin
      phase <= phase + 8'h01;
    end
  end

  // Ones counter, one bit taken per clock; the last bit of a window goes to the sample instead
  always_ff @(posedge clk) begin
    if (rst) begin
      ones <= '0;
    end else if (phase == DEC_LAST) begin
      ones <= '0; // Window closes
    end else begin
      ones <= ones + {8'h00, bit_in};
    end
  end

  // Sample out at window end
  always_ff @(posedge clk) begin
    if (rst) begin
      sample_valid <= 1'b0;
      sample <= '0;
    end else begin
      sample_valid <= (phase == DEC_LAST);
      if (phase == DEC_LAST) begin
        sample <= to_level(ones + {8'h00, bit_in});
      end
    end
  end

endmodule
`default_nettype wire

// ### verilog/act_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module act_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH]; // Storage
  logic [AW-1:0] wr_ptr; // Next write slot
  logic [AW-1:0] rd_ptr; // Oldest word
  logic [AW:0] count; // Words held
  logic push;
  logic pop;

  // Pointer advance with wrap at depth
  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  assign in_ready = (count != FULL);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  ////////////////////////////////////////////////////////////////////////////
  // Write port
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= next_ptr(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= next_ptr(rd_ptr);
      end
      if (push && !pop) begin
        count <= count + (AW+1)'(1);
      end else if (pop && !push) begin
        count <= count - (AW+1)'(1);
      end
    end
  end

endmodule
`default_nettype wire

// ### verilog/act_power.sv
// Active power datapath: decimation, current select, filters, product, pulses
//
// Operation
// - Only one current input feeds the product
// - One modulator bit taken per clock
// - Decimator yields signed 24-bit samples
// - High-pass removes dc from current samples
// - Power is current times voltage sample
// - Low-pass product gives active power
// - Low-rate pulses from long power accumulation
// - Calibration pulse uses short accumulation
// - Thresholds counted in power units, not time
// - Reverse flag follows sign at calibration pulses
// - Rate select picks one of four scalings
// - Undervoltage stops accumulation, silences pulse outputs
`timescale 1ns/1ps
`default_nettype none
module act_power
  import act_pkg::*;
#(
  parameter int LR_HIGH = LR_HIGH_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Modulator bitstreams from the pins
  input wire logic current_input_a,
  input wire logic current_input_b,
  input wire logic voltage_input_bit,
  // Control pins
  input wire logic current_select_b,
  input wire logic [1:0] rate_select,
  input wire logic supply_low,
  // Pulse and flag outputs
  output logic calibration_pulse_out,
  output logic low_rate_pulse_a,
  output logic low_rate_pulse_b,
  output logic reverse_power_flag,
  // Monitored, unused current channel
  output logic monitor_valid,
  output logic signed [SAMPLE_W-1:0] monitor_sample
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  localparam int SYNC_W = 7;

  logic [SYNC_W-1:0] sync_meta; // First synchroniser stage
  logic [SYNC_W-1:0] sync_q; // Second stage, safe to read
  logic bit_a; // Synchronised bits
  logic bit_b;
  logic bit_v;
  logic sel_b;
  logic [1:0] rate;
  logic low_supply;

  logic dec_valid; // Decimators run in lockstep
  logic signed [SAMPLE_W-1:0] samp_a;
  logic signed [SAMPLE_W-1:0] samp_b;
  logic signed [SAMPLE_W-1:0] samp_v;

  logic hold_valid; // Sample pair waiting for the FIFO
  act_pair_t hold_pair;
  logic fifo_in_ready;
  logic fifo_out_valid;
  act_pair_t fifo_out;
  logic take; // Processing takes a pair

  act_state_t state; // Processing sequence
  act_pair_t work; // Pair under processing
  logic signed [ACC_W-1:0] hpf_acc; // Current dc estimate, scaled
  logic signed [SAMPLE_W-1:0] cur_hp; // Current with dc removed
  logic signed [ACC_W-1:0] inst_power; // Instantaneous power
  logic signed [ACC_W-1:0] lpf_acc; // Low-pass state, scaled
  logic signed [ACC_W-1:0] active; // Active power
  logic primed; // First active value present

  logic [ACC_W-1:0] cf_acc; // Short accumulator
  logic [ACC_W-1:0] lr_acc; // Long accumulator
  logic cf_fire; // Calibration threshold reached
  logic lr_fire; // Low-rate threshold reached
  logic [31:0] cf_cnt; // Calibration high time left
  logic [31:0] lr_cnt; // Low-rate high time left
  logic lr_turn_b; // Next low-rate pulse goes to output b
  logic dfc_add; // New active value enters the accumulators

  // Magnitude of a signed power value
  function automatic logic [ACC_W-1:0] mag(input logic signed [ACC_W-1:0] v);
    mag = v[ACC_W-1] ? ACC_W'(-v) : ACC_W'(v);
  endfunction

  // Low-rate threshold for each rate code
  function automatic logic [ACC_W-1:0] lr_limit(input logic [1:0] code);
    unique case (code)
      RATE_X1: lr_limit = LR_THRESH;
      RATE_X2: lr_limit = LR_THRESH >> 1;
      RATE_X4: lr_limit = LR_THRESH >> 2;
      RATE_X8: lr_limit = LR_THRESH >> 3;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, two flops each
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_meta <= '0;
      sync_q <= '0;
    end else begin
      sync_meta <= {current_input_a, current_input_b, voltage_input_bit,
                    current_select_b, rate_select, supply_low};
      sync_q <= sync_meta;
    end
  end

  assign {bit_a, bit_b, bit_v, sel_b, rate, low_supply} = sync_q;

  ////////////////////////////////////////////////////////////////////////////
  // Decimators, one bit per clock on each channel
  act_decim u_dec_a (
    .clk(clk),
    .rst(rst),
    .bit_in(bit_a),
    .sample_valid(dec_valid),
    .sample(samp_a)
  );

  act_decim u_dec_b (
    .clk(clk),
    .rst(rst),
    .bit_in(bit_b),
    .sample_valid(),
    .sample(samp_b)
  );

  act_decim u_dec_v (
    .clk(clk),
    .rst(rst),
    .bit_in(bit_v),
    .sample_valid(),
    .sample(samp_v)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Channel select: product gets one current, the other is monitored
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_valid <= 1'b0;
      hold_pair <= '0;
    end else if (dec_valid) begin
      hold_valid <= 1'b1; // Newest pair replaces one not yet taken
      hold_pair.current <= sel_b ? samp_b : samp_a;
      hold_pair.voltage <= samp_v;
    end else if (fifo_in_ready) begin
      hold_valid <= 1'b0;
    end
  end

  // Monitor output of the channel left out of the product
  always_ff @(posedge clk) begin
    if (rst) begin
      monitor_valid <= 1'b0;
      monitor_sample <= '0;
    end else begin
      monitor_valid <= dec_valid;
      if (dec_valid) begin
        monitor_sample <= sel_b ? samp_a : samp_b;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample FIFO between decimation and processing
  act_fifo #(
    .WIDTH($bits(act_pair_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(hold_valid),
    .in_ready(fifo_in_ready),
    .in_data(hold_pair),
    .out_valid(fifo_out_valid),
    .out_ready(take),
    .out_data(fifo_out)
  );

  // Drain only while the sequence is idle
  assign take = (state == ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Processing sequence, one stage per clock
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (fifo_out_valid) begin
            state <= ST_HPF;
          end
        end
        ST_HPF: state <= ST_MUL;
        ST_MUL: state <= ST_LPF;
        ST_LPF: state <= ST_DFC;
        ST_DFC: state <= ST_IDLE;
        default: state <= ST_IDLE; // Recover from an illegal code
      endcase
    end
  end

  // Capture the pair being worked on
  always_ff @(posedge clk) begin
    if (rst) begin
      work <= '0;
    end else if (take && fifo_out_valid) begin
      work <= fifo_out;
    end
  end

  // High-pass on current: subtract a slow dc estimate
  always_ff @(posedge clk) begin
    if (rst) begin
      hpf_acc <= '0;
      cur_hp <= '0;
    end else if (state == ST_HPF) begin
      hpf_acc <= hpf_acc + ACC_W'(work.current) - (hpf_acc >>> HPF_SHIFT);
      cur_hp <= work.current - SAMPLE_W'(hpf_acc >>> HPF_SHIFT);
    end
  end

  // Direct product of filtered current and voltage
  always_ff @(posedge clk) begin
    if (rst) begin
      inst_power <= '0;
    end else if (state == ST_MUL) begin
      inst_power <= ACC_W'(cur_hp) * ACC_W'(work.voltage);
    end
  end

  // Low-pass on the product keeps its dc term
  always_ff @(posedge clk) begin
    if (rst) begin
      lpf_acc <= '0;
      active <= '0;
      primed <= 1'b0;
    end else if (state == ST_LPF) begin
      lpf_acc <= lpf_acc + (inst_power >>> LPF_SHIFT) - (lpf_acc >>> LPF_SHIFT);
      active <= lpf_acc >>> LPF_SHIFT;
      primed <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Energy accumulation, halted while the supply is low
  assign cf_fire = (cf_acc >= CF_THRESH);
  assign lr_fire = (lr_acc >= lr_limit(rate));
  assign dfc_add = (state == ST_DFC) && primed;

  always_ff @(posedge clk) begin
    if (rst) begin
      cf_acc <= '0;
      lr_acc <= '0;
    end else if (low_supply) begin
      cf_acc <= cf_acc;
      lr_acc <= lr_acc;
    end else begin
      // Pulse taken off and new energy added in one step, so no sample is lost
      cf_acc <= cf_acc - (cf_fire ? CF_THRESH : '0) + (dfc_add ? mag(active) : '0);
      lr_acc <= lr_acc - (lr_fire ? lr_limit(rate) : '0) + (dfc_add ? mag(active) : '0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Calibration pulse and reverse power flag
  always_ff @(posedge clk) begin
    if (rst) begin
      cf_cnt <= '0;
      calibration_pulse_out <= 1'b0;
      reverse_power_flag <= 1'b0;
    end else if (low_supply) begin
      cf_cnt <= '0;
      calibration_pulse_out <= 1'b0;
    end else if (cf_fire) begin
      cf_cnt <= 32'(CF_HIGH_CYC - 1);
      calibration_pulse_out <= 1'b1;
      reverse_power_flag <= active[ACC_W-1];
    end else if (cf_cnt != '0) begin
      cf_cnt <= cf_cnt - 32'h0000_0001;
    end else begin
      calibration_pulse_out <= 1'b0;
    end
  end

  // Low-rate pulses, alternating between the two outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      lr_cnt <= '0;
      lr_turn_b <= 1'b0;
      low_rate_pulse_a <= 1'b0;
      low_rate_pulse_b <= 1'b0;
    end else if (low_supply) begin
      lr_cnt <= '0;
      low_rate_pulse_a <= 1'b0;
      low_rate_pulse_b <= 1'b0;
    end else if (lr_fire) begin
      lr_cnt <= 32'(LR_HIGH - 1);
      lr_turn_b <= ~lr_turn_b;
      low_rate_pulse_a <= ~lr_turn_b;
      low_rate_pulse_b <= lr_turn_b;
    end else if (lr_cnt != '0) begin
      lr_cnt <= lr_cnt - 32'h0000_0001;
    end else begin
      low_rate_pulse_a <= 1'b0;
      low_rate_pulse_b <= 1'b0;
    end
  end

endmodule
`default_nettype wire
